// *** scms_pkg.sv ***
/*
 Constants, field layout and types of the system clock mode select block.
 Assumes one 250 MHz fabric clock and oscillator activity seen as ticks.
*/
`default_nettype none
package scms_pkg;

  // Register offsets on the plain register port
  localparam int ADDR_W = 2;
  localparam logic [1:0] OFS_CTRL = 2'h0;
  localparam logic [1:0] OFS_STAT = 2'h1;
  localparam logic [1:0] OFS_MASK = 2'h2;

  // Control register fields
  localparam int FREQ_LSB = 4;
  localparam int FREQ_MSB = 6;
  localparam int RUNNING_ON_CFG_CLOCK_BIT = 3;
  localparam int HTS_BIT = 2;
  localparam int LTS_BIT = 1;
  localparam int CHOOSE_BIT = 0;
  localparam logic [2:0] FREQ_RST = 3'h6;
  localparam logic [2:0] FREQ_SLOW = 3'h0;
  localparam logic CHOOSE_RST = 1'b0;
  localparam logic [5:0] DIV_FULL = 6'h3f;

  // Event bits of status and mask
  localparam int EV_W = 4;
  localparam int EV_FAIL = 0;
  localparam int EV_WARM = 1;
  localparam int EV_FAST = 2;
  localparam int EV_SLOW = 3;

  // Warm-up counts in oscillator edges
  localparam int WARM_W = 11;
  localparam logic [10:0] WARM_XTAL = 11'd1024;
  localparam logic [10:0] WARM_RC = 11'd2;
  localparam logic [10:0] WARM_NONE = 11'd0;

  // Clock loss timeout
  localparam int CLK_PERIOD_NS = 4;
  localparam int FAIL_TIME_NS = 2000;
  localparam int FAIL_CYCLES =
    (FAIL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FAIL_W = 12;

  // Oscillator mode field of the first configuration word
  typedef enum logic [2:0] {
    watch_crystal_mode    = 3'h0,
    mid_gain_crystal_mode = 3'h1,
    high_gain_crystal_mode = 3'h2,
    driven_clock_in_mode  = 3'h3,
    res_cap_io_mode       = 3'h4,
    res_cap_mode          = 3'h5,
    int_osc_all_io_mode   = 3'h6,
    int_osc_div_out_mode  = 3'h7
  } scms_mode_t;

  // System clock source, Gray along cfg -> fast -> slow
  typedef enum logic [1:0] {
    SRC_CFG  = 2'b00,
    SRC_FAST = 2'b01,
    SRC_SLOW = 2'b11
  } scms_src_t;

  typedef struct packed {
    scms_mode_t mode;
    logic       two_speed_en;
    logic       fail_safe_en;
  } scms_cfg_t;

  typedef struct packed {
    logic out;
    logic oe_b;
  } scms_pin_t;

endpackage : scms_pkg
`default_nettype wire

// *** scms_top.sv ***
/*
 Clock mode selection, start-up control and clock fail monitor.
 Assumes the configuration word is static, oscillator activity arrives as
 one-cycle ticks synchronous to clock, and the pin pad resolves oe_b.
*/
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module scms_top #(
  parameter int FAST_WARM = 16,
  parameter int SLOW_WARM = 4
) (
  input  wire logic                    clock,
  input  wire logic                    rst_b,
  input  wire scms_pkg::scms_cfg_t     cfg,
  input  wire logic                    osc_in_pin,
  input  wire logic                    fast_osc_tick,
  input  wire logic                    slow_osc_tick,
  input  wire logic                    sleep_wake,
  input  wire logic [1:0]              addr,
  input  wire logic [7:0]              wdata,
  input  wire logic                    wr,
  input  wire logic                    rd,
  output var  logic [7:0]              rdata_r,
  output var  logic                    irq_r,
  output var  logic                    sys_tick_r,
  output var  logic                    cpu_run_r,
  output var  logic                    fast_osc_en_r,
  output var  scms_pkg::scms_pin_t     osc_out_pin_r,
  output var  logic                    osc_in_is_gpio_r,
  output var  logic                    osc_out_is_gpio_r,
  output var  scms_pkg::scms_src_t     cur_src_r
);
  import scms_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Declarations

  // Warm-up and clock fail monitor state
  logic              osc_in_d_r;
  logic [WARM_W-1:0] warm_cnt_r;
  logic              warm_done_r;
  logic [FAIL_W-1:0] fail_cnt_r;
  logic              fail_r;

  // Internal oscillator state
  logic [7:0]        fast_cnt_r;
  logic              fast_st_r;
  logic [7:0]        slow_cnt_r;
  logic              slow_st_r;
  logic [5:0]        div_cnt_r;

  // Register, status and output state
  logic [2:0]        freq_r;
  logic              choose_r;
  logic [EV_W-1:0]   stat_r;
  logic [EV_W-1:0]   mask_r;
  logic              ph_r;
  logic              clkout_r;
  logic [7:0]        ctrl_rd;
  logic [EV_W-1:0]   ev;

  //////////////////////////////////////////////////////////////////////////
  // Mode decode from the configuration field

  wire is_xtal = (cfg.mode == watch_crystal_mode) ||
                 (cfg.mode == mid_gain_crystal_mode) ||
                 (cfg.mode == high_gain_crystal_mode);
  wire is_drv  = (cfg.mode == driven_clock_in_mode);
  wire is_rc   = (cfg.mode == res_cap_mode) ||
                 (cfg.mode == res_cap_io_mode);
  wire is_int  = (cfg.mode == int_osc_all_io_mode) ||
                 (cfg.mode == int_osc_div_out_mode);

  // Every mode that is not internal relies on an outside source
  wire is_ext  = ~is_int;

  // Pin usage per mode
  // Crystal modes leave the output pin to the resonator: neither
  // driven here nor free for I/O
  wire drive_out  = (cfg.mode == res_cap_mode) ||
                    (cfg.mode == int_osc_div_out_mode);
  wire in_gpio    = is_int;
  wire out_gpio   = is_drv ||
                    (cfg.mode == res_cap_io_mode) ||
                    (cfg.mode == int_osc_all_io_mode);

  //////////////////////////////////////////////////////////////////////////
  // Outside clock edges and warm-up count

  // Input pin is sampled as a synchronous level
  wire ext_edge = osc_in_pin & ~osc_in_d_r;

  // Crystals wait long, RC briefly, driven input not at all
  wire [WARM_W-1:0] warm_target =
    is_xtal ? WARM_XTAL :
    is_rc   ? WARM_RC   : WARM_NONE;
  wire warm_hit = (warm_cnt_r == warm_target);
  wire warm_set = ~warm_done_r & warm_hit & ~sleep_wake;
  wire [WARM_W-1:0] warm_cnt_nxt =
    sleep_wake ? WARM_NONE :
    (~warm_done_r & ~warm_hit & ext_edge) ?
      WARM_W'(warm_cnt_r + 1'b1) : warm_cnt_r;

  // A wake pulse restarts the count and, unless an internal start covers it, holds execution again
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      osc_in_d_r  <= 1'b0;
      warm_cnt_r  <= WARM_NONE;
      warm_done_r <= 1'b0;
    end else begin
      osc_in_d_r  <= osc_in_pin;
      warm_cnt_r  <= warm_cnt_nxt;
      warm_done_r <= ~sleep_wake & (warm_done_r | warm_set);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Clock fail monitor

  // Only watches once the outside clock has proven itself.
  // Limitation: a crystal or RC clock that never starts is not flagged;
  // its warm-up count simply never completes
  wire mon_on  = cfg.fail_safe_en & is_ext & warm_done_r & ~fail_r;
  wire fail_set = mon_on & ~ext_edge &
                  (fail_cnt_r == FAIL_W'(FAIL_CYCLES - 1));
  wire [FAIL_W-1:0] fail_cnt_nxt =
    (ext_edge | ~mon_on) ? '0 : FAIL_W'(fail_cnt_r + 1'b1);

  // Loss latches until reset; a flaky clock must not be trusted again
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fail_cnt_r <= '0;
      fail_r     <= 1'b0;
    end else begin
      fail_cnt_r <= fail_cnt_nxt;
      fail_r     <= fail_r | fail_set;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Internal oscillators and their stability

  // Internal run while the outside clock is still warming
  wire start_int = ((cfg.two_speed_en & is_xtal) |
                    (cfg.fail_safe_en & is_ext)) &
                   ~warm_done_r;
  wire use_int   = choose_r | fail_r | start_int;
  wire freq_slow = (freq_r == FREQ_SLOW);
  wire fast_need = ~freq_slow & (use_int | is_int);

  wire fast_hit = (fast_cnt_r == 8'(FAST_WARM));
  wire slow_hit = (slow_cnt_r == 8'(SLOW_WARM));
  wire fast_set = fast_osc_en_r & fast_hit & ~fast_st_r;
  wire slow_set = slow_hit & ~slow_st_r;
  wire [7:0] fast_cnt_nxt =
    ~fast_osc_en_r ? 8'h00 :
    (fast_osc_tick & ~fast_hit) ? 8'(fast_cnt_r + 1'b1) : fast_cnt_r;
  wire [7:0] slow_cnt_nxt =
    (slow_osc_tick & ~slow_hit) ? 8'(slow_cnt_r + 1'b1) : slow_cnt_r;

  // Fast stability drops as soon as the oscillator is switched off
  // The slow oscillator is never switched off, so its flag only rises
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fast_osc_en_r <= 1'b0;
      fast_cnt_r    <= 8'h00;
      fast_st_r     <= 1'b0;
      slow_cnt_r    <= 8'h00;
      slow_st_r     <= 1'b0;
    end else begin
      fast_osc_en_r <= fast_need;
      fast_cnt_r    <= fast_cnt_nxt;
      fast_st_r     <= fast_osc_en_r & (fast_st_r | fast_set);
      slow_cnt_r    <= slow_cnt_nxt;
      slow_st_r     <= slow_st_r | slow_set;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Postscaler of the fast oscillator

  // Mask halves per code step: code 7 passes every tick
  wire [5:0] div_mask = DIV_FULL >> (freq_r - 3'h1);
  wire       div_hit  = ((div_cnt_r & div_mask) == div_mask);
  wire       int_tick = freq_slow ? slow_osc_tick :
                        (fast_osc_tick & div_hit);
  wire       int_st   = freq_slow ? slow_st_r : fast_st_r;

  // Divider runs free on fast ticks. Trade-off: a code change is not
  // resynchronised, so the first period after it may be short
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_r <= 6'h00;
    end else if (fast_osc_tick) begin
      div_cnt_r <= 6'(div_cnt_r + 1'b1);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Source selection and glitch-free switch

  // In internal modes the configured clock is the postscaler itself
  wire cfg_tick = is_int ? int_tick : ext_edge;
  wire cfg_ok   = is_int ? int_st : (warm_done_r & ~fail_r);

  scms_src_t want_src;
  logic      want_ok;
  logic      cur_tick;

  // Wanted source: internal when chosen, failed or starting
  always_comb begin
    want_src = SRC_CFG;
    if (use_int) begin
      want_src = freq_slow ? SRC_SLOW : SRC_FAST;
    end
  end

  // Readiness of the wanted source
  always_comb begin
    want_ok = 1'b0;
    unique case (want_src)
      SRC_CFG:  want_ok = cfg_ok;
      SRC_FAST: want_ok = fast_st_r;
      SRC_SLOW: want_ok = slow_st_r;
      default:  want_ok = 1'b0;
    endcase
  end

  // Tick of the source in use
  always_comb begin
    cur_tick = 1'b0;
    unique case (cur_src_r)
      SRC_CFG:  cur_tick = cfg_tick;
      SRC_FAST: cur_tick = int_tick;
      SRC_SLOW: cur_tick = int_tick;
      default:  cur_tick = 1'b0;
    endcase
  end

  // Tick is blanked in the switch cycle so no runt edge escapes.
  // Trade-off: at most one tick is lost per switch, never a short one.
  wire switching = (want_src != cur_src_r) & want_ok;
  wire cpu_run_nxt = warm_done_r | start_int;
  // Gated by the next run level, so no tick outlives execution
  wire sys_tick_nxt = cur_tick & ~switching & cpu_run_nxt;

  // Execution waits for warm-up unless an internal source covers it
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cur_src_r  <= SRC_CFG;
      sys_tick_r <= 1'b0;
      cpu_run_r  <= 1'b0;
    end else begin
      if (switching) begin
        cur_src_r <= want_src;
      end
      sys_tick_r <= sys_tick_nxt;
      cpu_run_r  <= cpu_run_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Divided clock output and pin roles

  // Two ticks per half period give clock divided by four
  wire ph_nxt     = sys_tick_r ? ~ph_r : ph_r;
  wire clkout_nxt = (sys_tick_r & ph_r) ? ~clkout_r : clkout_r;

  // Pin roles are registered so the pads never see a decode glitch
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ph_r              <= 1'b0;
      clkout_r          <= 1'b0;
      osc_out_pin_r     <= '{out: 1'b0, oe_b: 1'b1};
      osc_in_is_gpio_r  <= 1'b0;
      osc_out_is_gpio_r <= 1'b0;
    end else begin
      ph_r              <= ph_nxt;
      clkout_r          <= clkout_nxt;
      osc_out_pin_r.out  <= drive_out & clkout_nxt;
      osc_out_pin_r.oe_b <= ~drive_out;
      osc_in_is_gpio_r  <= in_gpio;
      osc_out_is_gpio_r <= out_gpio;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register port decode

  // One select per register place, shared by writes and reads
  wire sel_ctrl = (addr == OFS_CTRL);
  wire sel_stat = (addr == OFS_STAT);
  wire sel_mask = (addr == OFS_MASK);

  wire wr_ctrl = wr & sel_ctrl;
  wire wr_stat = wr & sel_stat;
  wire wr_mask = wr & sel_mask;

  // Status bit: reads 0 while on internal, even from reset
  wire running_on_cfg_clock = (cur_src_r == SRC_CFG) & ~start_int;

  // Control image from field positions; bit 7 always reads zero
  always_comb begin
    ctrl_rd                    = 8'h00;
    ctrl_rd[FREQ_MSB:FREQ_LSB] = freq_r;
    ctrl_rd[RUNNING_ON_CFG_CLOCK_BIT]          = running_on_cfg_clock;
    ctrl_rd[HTS_BIT]           = fast_st_r;
    ctrl_rd[LTS_BIT]           = slow_st_r;
    ctrl_rd[CHOOSE_BIT]        = choose_r;
  end

  // Read mux; the unmapped place reads zero
  wire [7:0] rd_mux =
    sel_ctrl ? ctrl_rd :
    sel_stat ? {4'h0, stat_r} :
    sel_mask ? {4'h0, mask_r} : 8'h00;
  // Read data are zero outside the cycle after a read
  wire [7:0] rdata_nxt = rd ? rd_mux : 8'h00;

  // Events; a set in the clearing cycle wins
  always_comb begin
    ev          = '0;
    ev[EV_FAIL] = fail_set;
    ev[EV_WARM] = warm_set;
    ev[EV_FAST] = fast_set;
    ev[EV_SLOW] = slow_set;
  end

  // Clear only where software writes a one
  wire [EV_W-1:0] w1c = wr_stat ? wdata[EV_W-1:0] : '0;
  wire [EV_W-1:0] stat_nxt = (stat_r & ~w1c) | ev;

  // Bits 7 and 3 to 1 of the control word are never stored
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      freq_r   <= FREQ_RST;
      choose_r <= CHOOSE_RST;
      stat_r   <= '0;
      mask_r   <= '0;
      rdata_r  <= 8'h00;
      irq_r    <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        freq_r   <= wdata[FREQ_MSB:FREQ_LSB];
        choose_r <= wdata[CHOOSE_BIT];
      end
      if (wr_mask) begin
        mask_r <= wdata[EV_W-1:0];
      end
      stat_r  <= stat_nxt;
      rdata_r <= rdata_nxt;
      irq_r   <= |(stat_r & mask_r);
    end
  end

endmodule : scms_top
`default_nettype wire

// *** scms_chk.sv ***
/*
 Port checker of scms_top, bound onto every instance.
 Assumes cfg changes only under reset; a wake pulse may restart warm-up.
*/
`timescale 1ns/1ps
`default_nettype none
module scms_chk (
  input wire logic                clock,
  input wire logic                rst_b,
  input wire scms_pkg::scms_cfg_t cfg,
  input wire logic                osc_in_pin,
  input wire logic                rd,
  input wire logic [1:0]          addr,
  input wire logic [7:0]          rdata_r,
  input wire logic                sys_tick_r,
  input wire logic                cpu_run_r,
  input wire scms_pkg::scms_pin_t osc_out_pin_r,
  input wire logic                osc_in_is_gpio_r,
  input wire logic                osc_out_is_gpio_r,
  input wire scms_pkg::scms_src_t cur_src_r
);
  import scms_pkg::*;
  logic        in_q_r;
  logic [10:0] edges_r;
  logic [11:0] quiet_r;
  wire         xtal = cfg.mode <= high_gain_crystal_mode;
  wire         in_rise = osc_in_pin && !in_q_r;
  logic        aged_r;
  wire         aged = aged_r;

  // Edge count never lags the design's, so the hold check stays safe
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      aged_r  <= 1'b0;
      in_q_r  <= 1'b0;
      edges_r <= 11'h000;
      quiet_r <= 12'h000;
    end else begin
      aged_r  <= 1'b1;
      in_q_r  <= osc_in_pin;
      edges_r <= edges_r + {10'h000, in_rise && edges_r != 11'h7ff};
      quiet_r <= in_rise ? 12'h000 : quiet_r + {11'h000, quiet_r != 12'hfff};
    end
  end

  ////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  AST_BIT7_ZERO:
    assert property ($past(rd) && $past(addr) == OFS_CTRL |-> !rdata_r[7])
      else $error("control bit 7 read back as one");
  AST_DRIVEN_PINS:
    assert property (aged && cfg.mode == driven_clock_in_mode
      |-> osc_out_is_gpio_r && !osc_in_is_gpio_r)
      else $error("driven mode pin roles wrong");
  AST_RC_PINS:
    assert property (aged && cfg.mode == res_cap_mode
      |-> !osc_out_pin_r.oe_b && !osc_out_is_gpio_r)
      else $error("rc mode output pin not driving");
  AST_INT_OUT_PINS:
    assert property (aged && cfg.mode == int_osc_div_out_mode
      |-> osc_in_is_gpio_r && !osc_out_pin_r.oe_b)
      else $error("internal clock-out mode pin roles wrong");
  AST_INT_IO_PINS:
    assert property (aged && cfg.mode == int_osc_all_io_mode
      |-> osc_in_is_gpio_r && osc_out_is_gpio_r && osc_out_pin_r.oe_b)
      else $error("internal io mode pins not released");
  AST_TICK_NEEDS_RUN:
    assert property (sys_tick_r |-> cpu_run_r)
      else $error("system tick while execution held");
  AST_XTAL_HOLD:
    assert property (xtal && !cfg.two_speed_en && !cfg.fail_safe_en
      && edges_r <= 11'd1022 |-> !cpu_run_r)
      else $error("crystal mode ran before warm-up count");
  AST_DRIVEN_RUN:
    assert property (cfg.mode == driven_clock_in_mode && !cfg.fail_safe_en
      && $past(rst_b, 2) |-> cpu_run_r)
      else $error("driven mode delayed execution");
  AST_SRC_CODE:
    assert property (cur_src_r != 2'b10)
      else $error("illegal source code");
  AST_FAIL_SWITCH:
    assert property (cfg.fail_safe_en && cfg.mode == driven_clock_in_mode
      && quiet_r == 12'd520 |-> ##[0:400] cur_src_r != SRC_CFG)
      else $error("lost clock not replaced by internal");

  cover property (sys_tick_r && cur_src_r == SRC_SLOW);
  cover property ($rose(cpu_run_r) && xtal);
  cover property ($fell(osc_out_pin_r.out) && !osc_out_pin_r.oe_b);
endmodule : scms_chk

bind scms_top scms_chk u_scms_chk (.clock, .rst_b, .cfg, .osc_in_pin, .rd,
  .addr, .rdata_r, .sys_tick_r, .cpu_run_r, .osc_out_pin_r, .osc_in_is_gpio_r,
  .osc_out_is_gpio_r, .cur_src_r);
`default_nettype wire

// *** scms_osc_model.sv ***
/*
 Oscillator sources beside scms_top: outside clock and internal ticks.
 Assumes one fabric clock; rates are scaled far above the real ones.
*/
`timescale 1ns/1ps
`default_nettype none
module scms_osc_model (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic ext_run,
  input  wire logic fast_en,
  output var  logic osc_in_pin,
  output var  logic fast_osc_tick,
  output var  logic slow_osc_tick
);
  logic [3:0] cnt_r;

  ////////////////////////////////////////
  // Outside clock period 4 cycles, a cut clock rests low
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r         <= 4'h0;
      osc_in_pin    <= 1'b0;
      fast_osc_tick <= 1'b0;
      slow_osc_tick <= 1'b0;
    end else begin
      cnt_r         <= cnt_r + 4'h1;
      osc_in_pin    <= ext_run & cnt_r[1];
      fast_osc_tick <= fast_en & (cnt_r[1:0] == 2'h3);
      slow_osc_tick <= cnt_r == 4'hf;
    end
  end
endmodule : scms_osc_model
`default_nettype wire

// *** scms_tb_top.sv ***
/*
 Self-checking bench of scms_top driven through its register port.
 Assumes the oscillator model and the bound checker are compiled too.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  bad_count++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module scms_tb_top;
  import scms_pkg::*;
  logic       clock, rst_b, ext_run, sleep_wake, wr, rd, irq_r, sys_tick_r;
  logic       cpu_run_r, fast_osc_en_r, osc_in_is_gpio_r, osc_out_is_gpio_r;
  logic       osc_in_pin, fast_osc_tick, slow_osc_tick;
  logic [1:0] addr;
  logic [7:0] wdata, rdata_r;
  scms_cfg_t  cfg;
  scms_pin_t  osc_out_pin_r;
  scms_src_t  cur_src_r;
  int         bad_count, n_compared, t, k, e;

  scms_top #(.FAST_WARM(16), .SLOW_WARM(4)) u_scms_top (.clock, .rst_b,
    .cfg, .osc_in_pin, .fast_osc_tick, .slow_osc_tick, .sleep_wake, .addr,
    .wdata, .wr, .rd, .rdata_r, .irq_r, .sys_tick_r, .cpu_run_r,
    .fast_osc_en_r, .osc_out_pin_r, .osc_in_is_gpio_r, .osc_out_is_gpio_r,
    .cur_src_r);
  scms_osc_model u_scms_osc_model (.clock, .rst_b, .ext_run,
    .fast_en(fast_osc_en_r), .osc_in_pin, .fast_osc_tick, .slow_osc_tick);

  always #2 clock = ~clock;

  ////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc

  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand one cycle only, so look mid-cycle after the strobe
  task automatic rd_chk(input logic [1:0] a, input logic [7:0] m, e);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    `CHK("rdata", e, rdata_r & m)
    @(posedge clock);
  endtask : rd_chk

  task automatic boot(input scms_mode_t m, input logic ts, fs);
    @(posedge clock);
    rst_b <= 1'b0;
    cfg   <= '{m, ts, fs};
    cyc(20);
    rst_b <= 1'b1;
    cyc(2);
  endtask : boot

  // Counts system ticks and clock-out toggles over n cycles
  task automatic count(input int n, output int tk, output int tg);
    logic p;
    tk = 0;
    tg = 0;
    @(negedge clock);
    p = osc_out_pin_r.out;
    repeat (n) begin
      @(negedge clock);
      tk += int'(sys_tick_r);
      tg += int'(osc_out_pin_r.out != p);
      p = osc_out_pin_r.out;
    end
    @(posedge clock);
  endtask : count

  task automatic summarize();
    if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  ////////////////////////////////////////
  // Watchdog well above the roughly 25k cycles the tests need
  initial begin
    cyc(60000);
    bad_count++;
    summarize();
  end

  initial begin
    {clock, rst_b, wr, rd, sleep_wake, addr, wdata, cfg} = '0;
    ext_run = 1'b1;
    // Every mode: pin drive and control reset value
    for (int i = 0; i < 8; i++) begin
      boot(scms_mode_t'(i[2:0]), 1'b0, 1'b0);
      count(320, t, k);
      `CHK("drive", (i == 5 || i == 7), k > 0)
      rd_chk(OFS_CTRL, 8'hf9, 8'h68);
    end
    // Events, mask, interrupt, unmapped place, read-only bits
    boot(int_osc_div_out_mode, 1'b0, 1'b0);
    cyc(200);
    rd_chk(OFS_STAT, 8'h0c, 8'h0c);
    @(negedge clock);
    `CHK("irq", 1'b0, irq_r)
    wr_reg(OFS_MASK, 8'h04);
    cyc(2);
    @(negedge clock);
    `CHK("irq", 1'b1, irq_r)
    wr_reg(OFS_STAT, 8'h0f);
    cyc(2);
    @(negedge clock);
    `CHK("irq", 1'b0, irq_r)
    rd_chk(OFS_MASK, 8'hff, 8'h04);
    wr_reg(2'h3, 8'hff);
    rd_chk(2'h3, 8'hff, 8'h00);
    wr_reg(OFS_CTRL, 8'hff);
    cyc(200);
    rd_chk(OFS_CTRL, 8'hff, 8'h77);
    // Each frequency code halves the rate; code 0 takes the slow source
    for (int c = 7; c >= 0; c--) begin
      wr_reg(OFS_CTRL, {1'b0, c[2:0], 4'h1});
      cyc(300);
      count(1024, t, k);
      e = (c == 0) ? 64 : 256 >> (7 - c);
      `CHK("rate", 1'b1, t >= e - 1 && t <= e + 1)
      `CHK("clkout", 1'b1, k >= t / 2 - 1 && k <= t / 2 + 1)
      @(negedge clock);
      `CHK("fast_en", c != 0, fast_osc_en_r)
    end
    // Two-speed crystal start runs on internal, then hands over
    boot(mid_gain_crystal_mode, 1'b1, 1'b0);
    rd_chk(OFS_CTRL, 8'h08, 8'h00);
    cyc(100);
    @(negedge clock);
    `CHK("run", 1'b1, cpu_run_r)
    cyc(4200);
    rd_chk(OFS_CTRL, 8'h08, 8'h08);
    @(negedge clock);
    `CHK("src", SRC_CFG, cur_src_r)
    // Plain crystal start holds execution for the warm-up count
    boot(high_gain_crystal_mode, 1'b0, 1'b0);
    cyc(3900);
    @(negedge clock);
    `CHK("run", 1'b0, cpu_run_r)
    cyc(300);
    @(negedge clock);
    `CHK("run", 1'b1, cpu_run_r)
    // A wake from sleep restarts the crystal warm-up and holds execution
    @(posedge clock);
    sleep_wake <= 1'b1;
    @(posedge clock);
    sleep_wake <= 1'b0;
    cyc(3);
    @(negedge clock);
    `CHK("wake", 1'b0, cpu_run_r)
    // Outside clock lost under fail-safe monitoring
    boot(driven_clock_in_mode, 1'b0, 1'b1);
    cyc(50);
    @(negedge clock);
    `CHK("src", SRC_CFG, cur_src_r)
    @(posedge clock);
    ext_run <= 1'b0;
    cyc(1000);
    @(negedge clock);
    `CHK("src", 1'b1, cur_src_r != SRC_CFG)
    @(posedge clock);
    rd_chk(OFS_STAT, 8'h01, 8'h01);
    rd_chk(OFS_CTRL, 8'h08, 8'h00);
    summarize();
  end
endmodule : scms_tb_top
`default_nettype wire
